// ### logic/fsip_pkg.sv
// Constants and types shared by the integer pipeline
package fsip_pkg;
   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int XLEN = 64;
   localparam int NREG = 32;
   localparam int RIDX_W = 5;
   localparam int IMM_W = 16;
   localparam int OP_W = 4;
   localparam int SHAMT_W = 6;
   localparam int BE_W = 8;
   localparam int WORD_W = 32;
   localparam int LANE_BIT = 2;
   localparam logic [RIDX_W-1:0] ZERO_REG = 5'h00;
   // -----------------------------------------------------------------
   // Operation codes
   // -----------------------------------------------------------------
   localparam logic [OP_W-1:0] OP_NOP = 4'h0;
   localparam logic [OP_W-1:0] OP_ADD = 4'h1;
   localparam logic [OP_W-1:0] OP_SUB = 4'h2;
   localparam logic [OP_W-1:0] OP_AND = 4'h3;
   localparam logic [OP_W-1:0] OP_OR = 4'h4;
   localparam logic [OP_W-1:0] OP_XOR = 4'h5;
   localparam logic [OP_W-1:0] OP_SLL = 4'h6;
   localparam logic [OP_W-1:0] OP_SRL = 4'h7;
   localparam logic [OP_W-1:0] OP_LD = 4'h8;
   localparam logic [OP_W-1:0] OP_LW = 4'h9;
   localparam logic [OP_W-1:0] OP_SD = 4'ha;
   localparam logic [OP_W-1:0] OP_MFHI = 4'hb;
   localparam logic [OP_W-1:0] OP_MFLO = 4'hc;
   // -----------------------------------------------------------------
   // Store lane enables
   // -----------------------------------------------------------------
   localparam logic [BE_W-1:0] BE_ALL = 8'hff;
   // -----------------------------------------------------------------
   // Phase of each pipeline stage
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      PH1 = 2'b01,
      PH2 = 2'b10
   } fsip_phase_t;
endpackage : fsip_pkg

// ### logic/fsip_pipeline.sv
// Five-stage integer pipeline with register file, bypass and interlock
// Contract
// - Five stages, each in two phases
// - Thirty-two 64-bit general registers
// - Two read ports, one write port
// - Full bypass of in-flight results
// - Cache access and load align 2A-2D
// - Issue or slip decided in 1A
// - Add, logic, shift over 1A-2A
// - Load/store address computed in 1A
// - Single-cycle ALU; only loads/stores touch memory
// - Eight bytes per cycle on hit
// - Interlock dependencies, stall in hardware
// - Separate 64-bit multiply result pair
// - Result pair reaches file via move-from only
`timescale 1ns/100ps
`default_nettype none
module fsip_pipeline (
   // Clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // Decoded instruction from fetch
   input wire logic in_valid_in,
   input wire logic [fsip_pkg::OP_W-1:0] in_op_in,
   input wire logic [fsip_pkg::RIDX_W-1:0] in_rs_in,
   input wire logic [fsip_pkg::RIDX_W-1:0] in_rt_in,
   input wire logic [fsip_pkg::RIDX_W-1:0] in_rd_in,
   input wire logic [fsip_pkg::IMM_W-1:0] in_imm_in,
   output logic in_ready_out,
   output logic slip_out,
   // Data cache
   output logic dc_re_out,
   output logic dc_we_out,
   output logic [fsip_pkg::XLEN-1:0] dc_addr_out,
   output logic [fsip_pkg::XLEN-1:0] dc_wdata_out,
   output logic [fsip_pkg::BE_W-1:0] dc_be_out,
   input wire logic [fsip_pkg::XLEN-1:0] dc_rdata_in,
   // Multiply/divide unit
   input wire logic md_busy_in,
   input wire logic md_valid_in,
   input wire logic [fsip_pkg::XLEN-1:0] md_hi_in,
   input wire logic [fsip_pkg::XLEN-1:0] md_lo_in,
   // Write-back observation
   output logic wb_valid_out,
   output logic [fsip_pkg::RIDX_W-1:0] wb_reg_out,
   output logic [fsip_pkg::XLEN-1:0] wb_data_out
);
   localparam int XL = fsip_pkg::XLEN;
   localparam int RW = fsip_pkg::RIDX_W;
   localparam int OW = fsip_pkg::OP_W;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   fsip_pkg::fsip_phase_t phase_q, phase_d;
   logic [XL-1:0] rf_q [fsip_pkg::NREG];
   logic slip_q, slip_d, rdy_q, rdy_d;
   logic r_v_q, r_v_d, a_v_q, a_v_d, d_v_q, d_v_d, w_v_q, w_v_d;
   logic [OW-1:0] r_op_q, r_op_d, a_op_q, a_op_d, d_op_q, d_op_d;
   logic [RW-1:0] r_rs_q, r_rs_d, r_rt_q, r_rt_d;
   logic [RW-1:0] r_rd_q, r_rd_d, a_rd_q, a_rd_d, d_rd_q, d_rd_d;
   logic [RW-1:0] w_rd_q, w_rd_d;
   logic [fsip_pkg::IMM_W-1:0] r_imm_q, r_imm_d;
   logic [XL-1:0] a_x_q, a_x_d, a_y_q, a_y_d, a_addr_q, a_addr_d;
   logic [XL-1:0] a_imm_q, a_imm_d, d_res_q, d_res_d, w_res_q, w_res_d;
   logic d_lane_q, d_lane_d;
   logic [XL-1:0] hi_q, hi_d, lo_q, lo_d;
   logic re_q, re_d, we_q, we_d;
   logic [XL-1:0] addr_q, addr_d, wdat_q, wdat_d;
   logic [fsip_pkg::BE_W-1:0] be_q, be_d;
   logic wbv_q, wbv_d;
   logic [RW-1:0] wbr_q, wbr_d;
   logic [XL-1:0] wbd_q, wbd_d;
   logic rf_we;
   logic adv;
   logic [XL-1:0] a_res, d_final, lw_word;

   // Instruction writes a general register
   function automatic logic writes(input logic [OW-1:0] op);
      writes = (op != fsip_pkg::OP_NOP) && (op != fsip_pkg::OP_SD);
   endfunction : writes

   function automatic logic is_load(input logic [OW-1:0] op);
      is_load = (op == fsip_pkg::OP_LD) || (op == fsip_pkg::OP_LW);
   endfunction : is_load

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Operand from file or youngest in-flight producer
   function automatic logic [XL-1:0] fwd(input logic [RW-1:0] idx,
                                         input logic [XL-1:0] dres,
                                         input logic [XL-1:0] ares);
      if (idx == fsip_pkg::ZERO_REG) fwd = '0;
      else if (a_v_q && writes(a_op_q) && a_rd_q == idx) fwd = ares;
      else if (d_v_q && writes(d_op_q) && d_rd_q == idx) fwd = dres;
      else if (w_v_q && w_rd_q == idx) fwd = w_res_q;
      else fwd = rf_q[idx];
   endfunction : fwd

   // Execute-stage result and load alignment
   always_comb begin
      adv = (phase_q == fsip_pkg::PH2);
      a_addr_d = a_x_q + a_imm_q;
      case (a_op_q)
         fsip_pkg::OP_ADD: a_res = a_x_q + a_y_q;
         fsip_pkg::OP_SUB: a_res = a_x_q - a_y_q;
         fsip_pkg::OP_AND: a_res = a_x_q & a_y_q;
         fsip_pkg::OP_OR: a_res = a_x_q | a_y_q;
         fsip_pkg::OP_XOR: a_res = a_x_q ^ a_y_q;
         fsip_pkg::OP_SLL: a_res = a_x_q << a_imm_q[fsip_pkg::SHAMT_W-1:0];
         fsip_pkg::OP_SRL: a_res = a_x_q >> a_imm_q[fsip_pkg::SHAMT_W-1:0];
         fsip_pkg::OP_MFHI: a_res = hi_q;
         fsip_pkg::OP_MFLO: a_res = lo_q;
         default: a_res = a_addr_q;
      endcase
      // Word load picks its half and sign-extends in 2D
      lw_word = d_lane_q ? {{(XL-fsip_pkg::WORD_W){dc_rdata_in[XL-1]}},
                            dc_rdata_in[XL-1:fsip_pkg::WORD_W]}
                         : {{(XL-fsip_pkg::WORD_W){
                               dc_rdata_in[fsip_pkg::WORD_W-1]}},
                            dc_rdata_in[fsip_pkg::WORD_W-1:0]};
      if (d_op_q == fsip_pkg::OP_LD) d_final = dc_rdata_in;
      else if (d_op_q == fsip_pkg::OP_LW) d_final = lw_word;
      else d_final = d_res_q;
   end

   // Pipeline advance, interlock, cache strobes, register write
   always_comb begin
      phase_d = adv ? fsip_pkg::PH1 : fsip_pkg::PH2;
      slip_d = slip_q;
      rdy_d = 1'b0;
      r_v_d = r_v_q; r_op_d = r_op_q; r_rs_d = r_rs_q;
      r_rt_d = r_rt_q; r_rd_d = r_rd_q; r_imm_d = r_imm_q;
      a_v_d = a_v_q; a_op_d = a_op_q; a_rd_d = a_rd_q;
      a_x_d = a_x_q; a_y_d = a_y_q; a_imm_d = a_imm_q;
      d_v_d = d_v_q; d_op_d = d_op_q; d_rd_d = d_rd_q;
      d_res_d = d_res_q; d_lane_d = d_lane_q;
      w_v_d = w_v_q; w_rd_d = w_rd_q; w_res_d = w_res_q;
      re_d = 1'b0; we_d = 1'b0;
      addr_d = addr_q; wdat_d = wdat_q; be_d = be_q;
      wbv_d = 1'b0; wbr_d = wbr_q; wbd_d = wbd_q;
      rf_we = 1'b0;
      hi_d = md_valid_in ? md_hi_in : hi_q;
      lo_d = md_valid_in ? md_lo_in : lo_q;
      if (!adv) begin
         // Phase 1A: issue or slip, address out for 2A
         slip_d = r_v_q && ((a_v_q && is_load(a_op_q)
                  && a_rd_q != fsip_pkg::ZERO_REG
                  && (a_rd_q == r_rs_q || a_rd_q == r_rt_q))
                  || (md_busy_in && (r_op_q == fsip_pkg::OP_MFHI
                  || r_op_q == fsip_pkg::OP_MFLO)));
         rdy_d = !slip_d;
         re_d = a_v_q && is_load(a_op_q);
         we_d = a_v_q && (a_op_q == fsip_pkg::OP_SD);
         if (a_v_q && (is_load(a_op_q) || a_op_q == fsip_pkg::OP_SD)) begin
            addr_d = a_addr_d;
            wdat_d = a_y_q;
            be_d = fsip_pkg::BE_ALL;
         end
      end else begin
         // End of 2W: file write, then shift stages
         rf_we = w_v_q && (w_rd_q != fsip_pkg::ZERO_REG);
         wbv_d = rf_we;
         wbr_d = w_rd_q;
         wbd_d = w_res_q;
         w_v_d = d_v_q && writes(d_op_q);
         w_rd_d = d_rd_q;
         w_res_d = d_final;
         d_v_d = a_v_q; d_op_d = a_op_q; d_rd_d = a_rd_q;
         d_res_d = a_res;
         d_lane_d = a_addr_q[fsip_pkg::LANE_BIT];
         if (slip_q) begin
            a_v_d = 1'b0;
            a_op_d = fsip_pkg::OP_NOP;
         end else begin
            a_v_d = r_v_q; a_op_d = r_op_q; a_rd_d = r_rd_q;
            a_x_d = fwd(r_rs_q, d_final, a_res);
            a_y_d = fwd(r_rt_q, d_final, a_res);
            a_imm_d = {{(XL-fsip_pkg::IMM_W){r_imm_q[fsip_pkg::IMM_W-1]}},
                       r_imm_q};
            r_v_d = in_valid_in && rdy_q;
            r_op_d = in_op_in; r_rs_d = in_rs_in; r_rt_d = in_rt_in;
            r_rd_d = in_rd_in; r_imm_d = in_imm_in;
         end
         slip_d = 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         phase_q <= fsip_pkg::PH1;
         slip_q <= 1'b0; rdy_q <= 1'b0;
         r_v_q <= 1'b0; a_v_q <= 1'b0; d_v_q <= 1'b0; w_v_q <= 1'b0;
         r_op_q <= fsip_pkg::OP_NOP; a_op_q <= fsip_pkg::OP_NOP;
         d_op_q <= fsip_pkg::OP_NOP;
         r_rs_q <= '0; r_rt_q <= '0; r_rd_q <= '0; r_imm_q <= '0;
         a_rd_q <= '0; d_rd_q <= '0; w_rd_q <= '0;
         a_x_q <= '0; a_y_q <= '0; a_imm_q <= '0; a_addr_q <= '0;
         d_res_q <= '0; d_lane_q <= 1'b0; w_res_q <= '0;
         hi_q <= '0; lo_q <= '0;
         re_q <= 1'b0; we_q <= 1'b0; addr_q <= '0; wdat_q <= '0;
         be_q <= '0; wbv_q <= 1'b0; wbr_q <= '0; wbd_q <= '0;
      end else if (ce_in) begin
         phase_q <= phase_d;
         slip_q <= slip_d; rdy_q <= rdy_d;
         r_v_q <= r_v_d; a_v_q <= a_v_d; d_v_q <= d_v_d; w_v_q <= w_v_d;
         r_op_q <= r_op_d; a_op_q <= a_op_d; d_op_q <= d_op_d;
         r_rs_q <= r_rs_d; r_rt_q <= r_rt_d; r_rd_q <= r_rd_d;
         r_imm_q <= r_imm_d;
         a_rd_q <= a_rd_d; d_rd_q <= d_rd_d; w_rd_q <= w_rd_d;
         a_x_q <= a_x_d; a_y_q <= a_y_d; a_imm_q <= a_imm_d;
         a_addr_q <= a_addr_d;
         d_res_q <= d_res_d; d_lane_q <= d_lane_d; w_res_q <= w_res_d;
         hi_q <= hi_d; lo_q <= lo_d;
         re_q <= re_d; we_q <= we_d; addr_q <= addr_d; wdat_q <= wdat_d;
         be_q <= be_d; wbv_q <= wbv_d; wbr_q <= wbr_d; wbd_q <= wbd_d;
      end
   end

   // Register file write port
   always_ff @(posedge mclk_in) begin
      if (ce_in && rf_we) rf_q[w_rd_q] <= w_res_q;
   end

   // Outputs
   assign in_ready_out = rdy_q;
   assign slip_out = slip_q;
   assign dc_re_out = re_q;
   assign dc_we_out = we_q;
   assign dc_addr_out = addr_q;
   assign dc_wdata_out = wdat_q;
   assign dc_be_out = be_q;
   assign wb_valid_out = wbv_q;
   assign wb_reg_out = wbr_q;
   assign wb_data_out = wbd_q;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   phase_toggle_a: assert property (ce_in |=> phase_q != $past(phase_q))
      else $error("phase did not alternate");
   ready_phase_a: assert property (in_ready_out |-> phase_q == fsip_pkg::PH2)
      else $error("ready outside second phase");
   slip_noready_a: assert property (slip_out |-> !in_ready_out)
      else $error("ready while slipping");
   load_use_slip_a: assert property ((ce_in && phase_q == fsip_pkg::PH1
      && r_v_q && a_v_q && a_op_q == fsip_pkg::OP_LD
      && a_rd_q != fsip_pkg::ZERO_REG && a_rd_q == r_rs_q) |=> slip_out)
      else $error("load-use hazard not slipped");
   zero_nowrite_a: assert property (wb_valid_out |-> wb_reg_out != '0)
      else $error("write to register zero");
   wb_phase_a: assert property (wb_valid_out |-> phase_q == fsip_pkg::PH1)
      else $error("write not at end of second phase");
   wb_stored_a: assert property (wb_valid_out |-> rf_q[wb_reg_out] == wb_data_out)
      else $error("file does not hold written value");
   mem_excl_a: assert property (!(dc_re_out && dc_we_out))
      else $error("load and store strobes together");
   dc_strobe_a: assert property ((dc_re_out || dc_we_out) |->
      phase_q == fsip_pkg::PH2 ##1 !dc_re_out && !dc_we_out)
      else $error("cache strobe outside 2A");
   pair_load_a: assert property (md_valid_in && ce_in |=> lo_q == $past(md_lo_in))
      else $error("result pair not loaded");

   load_c: cover property (dc_re_out);
   store_c: cover property (dc_we_out);
   slip_c: cover property (slip_out ##2 in_ready_out);
   wb_c: cover property (wb_valid_out);
endmodule : fsip_pipeline
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the five-stage integer pipeline
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // -----------------------------------------------------------------
   // Signals and bench state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] op;
      logic [4:0] rs;
      logic [4:0] rt;
      logic [4:0] rd;
      logic [15:0] imm;
   } fsip_row_t;
   logic mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, in_valid_in = 1'b0;
   logic [3:0] in_op_in = 4'h0;
   logic [4:0] in_rs_in = 5'h00, in_rt_in = 5'h00, in_rd_in = 5'h00;
   logic [15:0] in_imm_in = 16'h0000;
   logic [63:0] dc_rdata_in = 64'h0, md_hi_in = 64'h0, md_lo_in = 64'h0;
   logic md_busy_in = 1'b0, md_valid_in = 1'b0;
   logic in_ready_out, slip_out, dc_re_out, dc_we_out, wb_valid_out;
   logic [63:0] dc_addr_out, dc_wdata_out, wb_data_out, hi_m, lo_m;
   logic [7:0] dc_be_out;
   logic [4:0] wb_reg_out;
   logic [63:0] rf [32];
   logic [68:0] wbq [$];
   logic [68:0] e;
   logic [63:0] stq [$];
   int n_fail = 0, total_checks = 0, n_slip = 0, cyc = 0, t_take = 0;
   int t_wb = 0, s0 = 0;
   fsip_row_t rows [15] = '{
      '{fsip_pkg::OP_LD, 5'h00, 5'h00, 5'h01, 16'h0100},
      '{fsip_pkg::OP_LD, 5'h00, 5'h00, 5'h02, 16'h0208},
      '{fsip_pkg::OP_LW, 5'h00, 5'h00, 5'h03, 16'h0314},
      '{fsip_pkg::OP_ADD, 5'h01, 5'h02, 5'h04, 16'h0000},
      '{fsip_pkg::OP_SUB, 5'h04, 5'h01, 5'h05, 16'h0000},
      '{fsip_pkg::OP_AND, 5'h05, 5'h02, 5'h06, 16'h0000},
      '{fsip_pkg::OP_OR, 5'h06, 5'h03, 5'h07, 16'h0000},
      '{fsip_pkg::OP_XOR, 5'h07, 5'h04, 5'h08, 16'h0000},
      '{fsip_pkg::OP_SLL, 5'h08, 5'h08, 5'h09, 16'h0025},
      '{fsip_pkg::OP_SRL, 5'h09, 5'h09, 5'h1f, 16'h0007},
      '{fsip_pkg::OP_SD, 5'h00, 5'h1f, 5'h00, 16'h0400},
      '{fsip_pkg::OP_ADD, 5'h01, 5'h02, 5'h00, 16'h0000},
      '{fsip_pkg::OP_OR, 5'h00, 5'h01, 5'h0b, 16'h0000},
      '{fsip_pkg::OP_LD, 5'h00, 5'h00, 5'h0c, 16'hfff8},
      '{fsip_pkg::OP_ADD, 5'h0c, 5'h00, 5'h0d, 16'h0000}};
   // -----------------------------------------------------------------
   // Device under test and clock
   // -----------------------------------------------------------------
   fsip_pipeline u_fsip_pipeline (.mclk_in(mclk_in), .rst_in(rst_in),
      .ce_in(ce_in), .in_valid_in(in_valid_in), .in_op_in(in_op_in),
      .in_rs_in(in_rs_in), .in_rt_in(in_rt_in), .in_rd_in(in_rd_in),
      .in_imm_in(in_imm_in), .in_ready_out(in_ready_out),
      .slip_out(slip_out), .dc_re_out(dc_re_out), .dc_we_out(dc_we_out),
      .dc_addr_out(dc_addr_out), .dc_wdata_out(dc_wdata_out),
      .dc_be_out(dc_be_out), .dc_rdata_in(dc_rdata_in),
      .md_busy_in(md_busy_in), .md_valid_in(md_valid_in),
      .md_hi_in(md_hi_in), .md_lo_in(md_lo_in),
      .wb_valid_out(wb_valid_out), .wb_reg_out(wb_reg_out),
      .wb_data_out(wb_data_out));
   initial begin
      forever #50 mclk_in = ~mclk_in;
   end
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [63:0] mem_word(input logic [63:0] a);
      logic [31:0] w;
      w = a[31:0] ^ 32'hda3c_9671;
      return {~w, w}; // Halves differ so lane choice shows
   endfunction : mem_word
   task automatic check(input string name, input logic [63:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("TB: checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   // Present one instruction, hold it until taken, update the model
   task automatic issue(input fsip_row_t r);
      logic [63:0] a, b, ea, res, m;
      int k;
      a = rf[r.rs];
      b = rf[r.rt];
      ea = a + {{48{r.imm[15]}}, r.imm};
      m = mem_word(ea);
      in_valid_in <= 1'b1;
      in_op_in <= r.op;
      in_rs_in <= r.rs;
      in_rt_in <= r.rt;
      in_rd_in <= r.rd;
      in_imm_in <= r.imm;
      for (k = 0; k < 60; k++) begin
         @(posedge mclk_in);
         if (in_ready_out === 1'b1 && ce_in === 1'b1) break;
      end
      if (k == 60) begin
         n_fail++;
         stop_test();
      end
      t_take = cyc;
      case (r.op)
         fsip_pkg::OP_ADD: res = a + b;
         fsip_pkg::OP_SUB: res = a - b;
         fsip_pkg::OP_AND: res = a & b;
         fsip_pkg::OP_OR: res = a | b;
         fsip_pkg::OP_XOR: res = a ^ b;
         fsip_pkg::OP_SLL: res = a << r.imm[5:0];
         fsip_pkg::OP_SRL: res = a >> r.imm[5:0];
         fsip_pkg::OP_LD: res = m;
         fsip_pkg::OP_LW: res = ea[2] ? {{32{m[63]}}, m[63:32]}
                                      : {{32{m[31]}}, m[31:0]};
         fsip_pkg::OP_MFHI: res = hi_m;
         fsip_pkg::OP_MFLO: res = lo_m;
         default: res = 64'h0;
      endcase
      if (r.op == fsip_pkg::OP_SD) begin
         stq.push_back(ea);
         stq.push_back(b);
      end
      if (r.op != fsip_pkg::OP_SD && r.op != fsip_pkg::OP_NOP && r.rd != 0) begin
         rf[r.rd] = res;
         wbq.push_back({r.rd, res});
      end
   endtask : issue
   // Wait until every expected write and store has been seen
   task automatic drain;
      int k;
      for (k = 0; k < 200; k++) begin
         @(posedge mclk_in);
         if (wbq.size() == 0 && stq.size() == 0) break;
      end
      if (k == 200) begin
         n_fail++;
         stop_test();
      end
      @(posedge mclk_in);
   endtask : drain
   // -----------------------------------------------------------------
   // Cache model and result monitor
   // -----------------------------------------------------------------
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (!rst_in && ce_in) begin
         if (slip_out === 1'b1) n_slip <= n_slip + 1;
         if (dc_re_out === 1'b1) dc_rdata_in <= mem_word(dc_addr_out);
         if (dc_we_out === 1'b1 && stq.size() < 2) check("store", 1, 0);
         else if (dc_we_out === 1'b1) begin
            check("store addr", dc_addr_out, stq.pop_front());
            check("store data", dc_wdata_out, stq.pop_front());
            check("store lanes", {56'h0, dc_be_out}, 64'hff);
         end
         if (wb_valid_out === 1'b1 && wbq.size() == 0) check("extra wb", 1, 0);
         else if (wb_valid_out === 1'b1) begin
            t_wb <= cyc;
            e = wbq.pop_front();
            check("wb reg", {59'h0, wb_reg_out}, {59'h0, e[68:64]});
            check("wb data", wb_data_out, e[63:0]);
         end
      end
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      rf[0] = 64'h0;
      repeat (20) @(posedge mclk_in);
      check("ready in reset", {63'h0, in_ready_out}, 64'h0);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      foreach (rows[i]) issue(rows[i]);
      in_valid_in <= 1'b0;
      drain();
      check("load-use slip", {63'h0, n_slip > 0}, 64'h1);
      $display("TB: table rows done");
      issue(fsip_row_t'{fsip_pkg::OP_ADD, 5'h01, 5'h02, 5'h0e, 16'h0000});
      in_valid_in <= 1'b0;
      drain();
      check("latency", 64'(t_wb - t_take), 64'd9);
      issue(fsip_row_t'{fsip_pkg::OP_ADD, 5'h0e, 5'h01, 5'h0f, 16'h0000});
      in_valid_in <= 1'b0;
      ce_in <= 1'b0;
      repeat (10) @(posedge mclk_in);
      ce_in <= 1'b1;
      drain();
      check("frozen latency", 64'(t_wb - t_take), 64'd19);
      $display("TB: latency and freeze done");
      hi_m = 64'hfedc_ba98_7654_3210;
      lo_m = 64'h0f1e_2d3c_4b5a_6978;
      md_hi_in <= hi_m;
      md_lo_in <= lo_m;
      md_valid_in <= 1'b1;
      @(posedge mclk_in);
      md_valid_in <= 1'b0;
      md_busy_in <= 1'b1;
      s0 = n_slip;
      repeat (6) @(posedge mclk_in);
      fork
         issue(fsip_row_t'{fsip_pkg::OP_MFHI, 5'h00, 5'h00, 5'h10, 16'h0000});
         begin
            repeat (12) @(posedge mclk_in);
            md_busy_in <= 1'b0;
         end
      join
      issue(fsip_row_t'{fsip_pkg::OP_MFLO, 5'h00, 5'h00, 5'h11, 16'h0000});
      in_valid_in <= 1'b0;
      drain();
      check("busy slip", {63'h0, n_slip > s0}, 64'h1);
      $display("TB: result pair done");
      issue(fsip_row_t'{fsip_pkg::OP_ADD, 5'h01, 5'h02, 5'h12, 16'h0000});
      in_valid_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b1;
      wbq.delete();
      repeat (20) @(posedge mclk_in);
      check("wb in reset", {63'h0, wb_valid_out}, 64'h0);
      check("re in reset", {63'h0, dc_re_out}, 64'h0);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      issue(fsip_row_t'{fsip_pkg::OP_XOR, 5'h04, 5'h05, 5'h13, 16'h0000});
      in_valid_in <= 1'b0;
      drain();
      $display("TB: mid-run reset done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
